/* File: src/thermo_defs.svh */
// Constants for the thermometer and clock command decoder
// What this block does
// - Answer control byte 9Eh; low bit selects direction
// - ACh writes config; reads config then status
// - ADh writes or reads resolution register
// - Resolution codes 00..11 give 9..12 bits; default 12
// - EEh starts conversion; one-shot or continuous
// - Stored power-up bit decides conversion after reset
// - 22h stops after finishing current conversion
// - AAh returns last result, high byte first
// - C0h addressed calendar access, address byte first
// - C7h addressed clock alarm access, address first
// - Calendar or alarm access clears clock alarm flag
// - A1h writes or reads two-byte high threshold
// - A2h writes or reads two-byte low threshold
// - 17h addressed SRAM access, pointer auto increments
// - SRAM pointer wraps from 1Fh to 00h
`ifndef THERMO_DEFS_SVH
`define THERMO_DEFS_SVH

// ****************************************
// Link protocol
// ****************************************
`define CTRL_BYTE 8'h9e
`define CMD_CONFIG 8'hac
`define CMD_RESOL 8'had
`define CMD_START 8'hee
`define CMD_STOP 8'h22
`define CMD_TEMP 8'haa
`define CMD_THI 8'ha1
`define CMD_TLO 8'ha2
`define CMD_CLOCK 8'hc0
`define CMD_CALRM 8'hc7
`define CMD_SRAM 8'h17
`define IDLE_BYTE 8'hff
`define BITS_PER_BYTE 4'h8
`define TX_LAST_BIT 3'h7
`define IDX_CMD 3'h0
`define IDX_FIRST 3'h1
`define IDX_SECOND 3'h2
`define IDX_MAX 3'h7
`define SRAM_AW 5

// ****************************************
// Stored settings
// ****************************************
`define CFG_RESET 8'h00
`define RES_RESET 2'h3
`define CFG_CNV_BIT 0
`define CFG_ONESHOT_BIT 1

// ****************************************
// Register bus map
// ****************************************
`define REG_EVT_STATUS 8'h00
`define REG_EVT_CLEAR 8'h04
`define REG_EVT_ENABLE 8'h08
`define REG_CTRL 8'h0c
`define REG_STATE 8'h10
`define EVT_W 3
`define EVT_CMD 0
`define EVT_STORE 1
`define EVT_CALCLR 2
`define CTRL_EN_BIT 0
`define CTRL_RESET 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/thermo_pkg.sv */
// Types shared by the command decoder and its parts
package thermo_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_ACK   = 6'h04,
    ST_RX    = 6'h08,
    ST_TX    = 6'h10,
    ST_TXACK = 6'h20
  } link_state_e;

  typedef struct packed {
    logic wr;
    logic alarm_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cal_req_s;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } thresh_s;

endpackage : thermo_pkg

/* File: src/pin_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {WIDTH{1'b1}};
      dout <= {WIDTH{1'b1}};
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : pin_sync

/* File: src/sram_store.sv */
// User SRAM array, one write port and one read port
`timescale 1ns/100ps
module sram_store #(
  parameter int AW = 5
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Contents are undefined after power-up, as for volatile storage
  assign rdata = mem[raddr];
endmodule : sram_store

/* File: src/thermo_rtc_command_decoder.sv */
// Serial-link command decoder for thermometer and calendar stores
`timescale 1ns/100ps
`include "thermo_defs.svh"
module thermo_rtc_command_decoder
  import thermo_pkg::*;
#(
  parameter logic [7:0] CFG_RESET_VALUE = `CFG_RESET,
  parameter int AXI_AW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial link pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Thermometer side
  input wire logic [15:0] temp_result,
  input wire logic [7:0] status_byte,
  input wire logic conv_done,
  output logic conv_run,
  output logic [7:0] config_byte,
  output logic [1:0] resolution_sel,
  output thresh_s thresholds,
  // Calendar and clock alarm side
  output cal_req_s cal_req,
  input wire logic [7:0] cal_rdata,
  output logic clock_alarm_clear,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic is_addressed(input logic [7:0] c);
    return (c == `CMD_CLOCK) || (c == `CMD_CALRM) || (c == `CMD_SRAM);
  endfunction : is_addressed

  function automatic logic reg_known(input logic [AXI_AW-1:0] a);
    return a <= `REG_STATE && a[1:0] == 2'h0;
  endfunction : reg_known

  // ****************************************
  // Pin sampling and bus conditions
  // ****************************************
  logic [1:0] pins_s;
  logic scl_p_q, sda_p_q;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  pin_sync #(.WIDTH(2)) u_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .din({scl_i, sda_i}),
    .dout(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ****************************************
  // Byte engine
  // ****************************************
  link_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_sh_q, tx_sh_q, tx_byte;
  logic rw_q, nack_q, slave_en_q;
  logic ctrl_wr_p_q, rx_p_q, rd_ack_p_q, tx_load_p_q;
  logic [7:0] rx_data_q;

  // Open drain: only ever pulls low, the enable carries the data
  assign sda_o = 1'b0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
      ctrl_wr_p_q <= 1'b0;
      rx_p_q <= 1'b0;
      rd_ack_p_q <= 1'b0;
      tx_load_p_q <= 1'b0;
      rx_data_q <= 8'h00;
    end else begin
      ctrl_wr_p_q <= 1'b0;
      rx_p_q <= 1'b0;
      rd_ack_p_q <= 1'b0;
      tx_load_p_q <= 1'b0;
      if (start_det) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              rx_sh_q <= {rx_sh_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
              bit_cnt_q <= 4'h0;
              if (state_q == ST_RX) begin
                rx_p_q <= 1'b1;
                rx_data_q <= rx_sh_q;
                sda_oe <= 1'b1;
                state_q <= ST_ACK;
              end else if (slave_en_q &&
                           rx_sh_q[7:1] == `CTRL_BYTE >> 1) begin
                rw_q <= rx_sh_q[0];
                ctrl_wr_p_q <= ~rx_sh_q[0];
                sda_oe <= 1'b1;
                state_q <= ST_ACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (rw_q) begin
                tx_sh_q <= tx_byte;
                tx_load_p_q <= 1'b1;
                sda_oe <= ~tx_byte[7];
                state_q <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q[2:0] == `TX_LAST_BIT) begin
                sda_oe <= 1'b0;
                state_q <= ST_TXACK;
              end else begin
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                sda_oe <= ~tx_sh_q[6];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              nack_q <= sda_s;
              rd_ack_p_q <= ~sda_s;
            end else if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (!nack_q) begin
                tx_sh_q <= tx_byte;
                tx_load_p_q <= 1'b1;
                sda_oe <= ~tx_byte[7];
                state_q <= ST_TX;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Command decode and stores
  // ****************************************
  logic [7:0] cmd_q;
  logic [2:0] wr_idx_q, rd_idx_q;
  logic [7:0] ptr_q;
  logic [7:0] sram_rdata;
  logic sram_we_q;
  logic [`SRAM_AW-1:0] sram_waddr_q;
  logic [7:0] sram_wdata_q;
  logic start_cmd, stop_cmd;
  logic [`EVT_W-1:0] evt_set;
  logic [7:0] next_ptr;

  assign next_ptr = (cmd_q == `CMD_SRAM) ?
    {3'h0, ptr_q[`SRAM_AW-1:0] + 5'h1} : ptr_q + 8'h1;
  assign start_cmd = rx_p_q && wr_idx_q == `IDX_CMD &&
                     rx_data_q == `CMD_START;
  assign stop_cmd = rx_p_q && wr_idx_q == `IDX_CMD &&
                    rx_data_q == `CMD_STOP;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= 8'h00;
      wr_idx_q <= `IDX_CMD;
      rd_idx_q <= `IDX_CMD;
      ptr_q <= 8'h00;
      config_byte <= CFG_RESET_VALUE;
      resolution_sel <= `RES_RESET;
      thresholds <= '0;
      cal_req <= '0;
      clock_alarm_clear <= 1'b0;
      sram_we_q <= 1'b0;
      sram_waddr_q <= '0;
      sram_wdata_q <= 8'h00;
      evt_set <= '0;
    end else begin
      cal_req.wr <= 1'b0;
      clock_alarm_clear <= 1'b0;
      sram_we_q <= 1'b0;
      evt_set <= '0;
      cal_req.addr <= ptr_q;
      cal_req.alarm_sel <= (cmd_q == `CMD_CALRM);
      if (state_q == ST_ADDR) begin
        rd_idx_q <= `IDX_CMD;
      end
      if (ctrl_wr_p_q) begin
        wr_idx_q <= `IDX_CMD;
      end else if (rx_p_q) begin
        if (wr_idx_q != `IDX_MAX) begin
          wr_idx_q <= wr_idx_q + 3'h1;
        end
        if (wr_idx_q == `IDX_CMD) begin
          cmd_q <= rx_data_q;
          rd_idx_q <= `IDX_CMD;
          evt_set[`EVT_CMD] <= 1'b1;
        end else begin
          case (cmd_q)
            `CMD_CONFIG: begin
              if (wr_idx_q == `IDX_FIRST) begin
                config_byte <= rx_data_q;
                evt_set[`EVT_STORE] <= 1'b1;
              end
            end
            `CMD_RESOL: begin
              if (wr_idx_q == `IDX_FIRST) begin
                resolution_sel <= rx_data_q[1:0];
                evt_set[`EVT_STORE] <= 1'b1;
              end
            end
            `CMD_THI, `CMD_TLO: begin
              if (wr_idx_q == `IDX_FIRST || wr_idx_q == `IDX_SECOND) begin
                if (cmd_q == `CMD_THI && wr_idx_q == `IDX_FIRST) begin
                  thresholds.high[15:8] <= rx_data_q;
                end else if (cmd_q == `CMD_THI) begin
                  thresholds.high[7:0] <= rx_data_q;
                end else if (wr_idx_q == `IDX_FIRST) begin
                  thresholds.low[15:8] <= rx_data_q;
                end else begin
                  thresholds.low[7:0] <= rx_data_q;
                end
                evt_set[`EVT_STORE] <= (wr_idx_q == `IDX_SECOND);
              end
            end
            `CMD_CLOCK, `CMD_CALRM, `CMD_SRAM: begin
              if (wr_idx_q == `IDX_FIRST) begin
                ptr_q <= (cmd_q == `CMD_SRAM) ?
                  {3'h0, rx_data_q[`SRAM_AW-1:0]} : rx_data_q;
              end else if (cmd_q == `CMD_SRAM) begin
                sram_we_q <= 1'b1;
                sram_waddr_q <= ptr_q[`SRAM_AW-1:0];
                sram_wdata_q <= rx_data_q;
                ptr_q <= next_ptr;
              end else begin
                cal_req.wr <= 1'b1;
                cal_req.wdata <= rx_data_q;
                ptr_q <= next_ptr;
                clock_alarm_clear <= 1'b1;
                evt_set[`EVT_CALCLR] <= 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end else if (tx_load_p_q && (cmd_q == `CMD_CLOCK ||
                                   cmd_q == `CMD_CALRM)) begin
        clock_alarm_clear <= 1'b1;
        evt_set[`EVT_CALCLR] <= 1'b1;
      end else if (rd_ack_p_q) begin
        if (is_addressed(cmd_q)) begin
          ptr_q <= next_ptr;
        end else if (rd_idx_q != `IDX_MAX) begin
          rd_idx_q <= rd_idx_q + 3'h1;
        end
      end
    end
  end

  sram_store #(.AW(`SRAM_AW)) u_sram (
    .clk(mclk),
    .we(sram_we_q),
    .waddr(sram_waddr_q),
    .wdata(sram_wdata_q),
    .raddr(ptr_q[`SRAM_AW-1:0]),
    .rdata(sram_rdata)
  );

  always_comb begin
    tx_byte = `IDLE_BYTE;
    case (cmd_q)
      `CMD_CONFIG: tx_byte = (rd_idx_q == `IDX_CMD) ?
                             config_byte : status_byte;
      `CMD_RESOL: tx_byte = {6'h00, resolution_sel};
      `CMD_TEMP: tx_byte = (rd_idx_q == `IDX_CMD) ?
                           temp_result[15:8] : temp_result[7:0];
      `CMD_THI: tx_byte = (rd_idx_q == `IDX_CMD) ?
                          thresholds.high[15:8] :
                          thresholds.high[7:0];
      `CMD_TLO: tx_byte = (rd_idx_q == `IDX_CMD) ?
                          thresholds.low[15:8] :
                          thresholds.low[7:0];
      `CMD_CLOCK, `CMD_CALRM: tx_byte = cal_rdata;
      `CMD_SRAM: tx_byte = sram_rdata;
      default: tx_byte = `IDLE_BYTE;
    endcase
  end

  // ****************************************
  // Conversion control
  // ****************************************
  logic boot_q, oneshot_q, stop_pend_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      boot_q <= 1'b0;
      conv_run <= 1'b0;
      oneshot_q <= 1'b0;
      stop_pend_q <= 1'b0;
    end else if (!boot_q) begin
      boot_q <= 1'b1;
      conv_run <= CFG_RESET_VALUE[`CFG_CNV_BIT];
      oneshot_q <= CFG_RESET_VALUE[`CFG_ONESHOT_BIT];
    end else if (start_cmd) begin
      conv_run <= 1'b1;
      oneshot_q <= config_byte[`CFG_ONESHOT_BIT];
      stop_pend_q <= 1'b0;
    end else if (stop_cmd) begin
      stop_pend_q <= conv_run;
    end else if (conv_done && conv_run && (oneshot_q || stop_pend_q)) begin
      // Current measurement always completes before idling
      conv_run <= 1'b0;
      stop_pend_q <= 1'b0;
    end
  end

  // ****************************************
  // Register bus and interrupt
  // ****************************************
  logic aw_held_q, w_held_q, do_write;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wlane0_q;
  logic [`EVT_W-1:0] evt_status_q, evt_enable_q, evt_clr;

  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign evt_clr = (do_write && wlane0_q && awaddr_q == `REG_EVT_CLEAR) ?
                   wdata_q[`EVT_W-1:0] : '0;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wlane0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      evt_enable_q <= '0;
      slave_en_q <= `CTRL_RESET;
    end else begin
      s_axi_awready <= ~aw_held_q & ~s_axi_bvalid & ~do_write &
                       ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held_q & ~s_axi_bvalid & ~do_write &
                      ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wlane0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_known(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
        if (wlane0_q && awaddr_q == `REG_EVT_ENABLE) begin
          evt_enable_q <= wdata_q[`EVT_W-1:0];
        end
        if (wlane0_q && awaddr_q == `REG_CTRL) begin
          slave_en_q <= wdata_q[`CTRL_EN_BIT];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `REG_EVT_STATUS: s_axi_rdata <= {29'h0, evt_status_q};
          `REG_EVT_ENABLE: s_axi_rdata <= {29'h0, evt_enable_q};
          `REG_CTRL: s_axi_rdata <= {31'h0, slave_en_q};
          `REG_STATE: s_axi_rdata <= {21'h0, conv_run, resolution_sel,
                                      cmd_q};
          default: s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      evt_status_q <= '0;
      irq <= 1'b0;
    end else begin
      evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
      irq <= |(evt_status_q & evt_enable_q);
    end
  end

endmodule : thermo_rtc_command_decoder

/* File: sim/thermo_checks_asserts.sv */
// Port assertions for the command decoder
`timescale 1ns/100ps
module thermo_checks
  import thermo_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Link and converter
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic conv_done,
  input wire logic conv_run,
  input wire logic [1:0] resolution_sel,
  input wire cal_req_s cal_req,
  input wire logic clock_alarm_clear,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  property p_rd_ans;
    s_ar_taken |=> s_r_answer;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken early");
  property p_sda_od;
    sda_oe |-> !sda_o;
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("data pin driven high");
  property p_oe_stable;
    scl_i && $past(scl_i) |-> $stable(sda_oe);
  endproperty
  a_oe_stable: assert property (p_oe_stable) else $error("data moved, clock high");
  property p_res_boot;
    !$past(rst_b) |-> resolution_sel == 2'h3;
  endproperty
  a_res_boot: assert property (p_res_boot) else $error("resolution not 12 bit");
  property p_conv_stop;
    $fell(conv_run) |-> $past(conv_done) || $past(conv_done, 2);
  endproperty
  a_conv_stop: assert property (p_conv_stop) else $error("run ended early");
  property p_clr_pulse;
    clock_alarm_clear |=> !clock_alarm_clear;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear too long");
  property p_wr_pulse;
    cal_req.wr |=> !cal_req.wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("calendar write long");
endmodule : thermo_checks

bind thermo_rtc_command_decoder thermo_checks i_thermo_checks (.*);

/* File: sim/link_master.sv */
// Serial link master model, 160 ns bit period
`timescale 1ns/100ps
module link_master (
  // Link lines
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic bit_io(input logic v, output logic s);
    sda_m = v;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
    #40;
  endtask : bit_io
  // Edges land on system clock falls, clear of sampling
  task automatic start_c();
    #(10 - $time % 10) sda_m = 1'b1;
    #40 scl = 1'b1;
    #40 sda_m = 1'b0;
    #40 scl = 1'b0;
    #40;
  endtask : start_c
  task automatic stop_c();
    sda_m = 1'b0;
    #40 scl = 1'b1;
    #40 sda_m = 1'b1;
    #40;
  endtask : stop_c
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte
  // Last byte gets a NACK so the device lets go
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask : rd_byte
endmodule : link_master

/* File: sim/thermo_rtc_command_decoder_tb_top.sv */
// Self-checking bench for the command decoder
`timescale 1ns/100ps
`include "thermo_defs.svh"
module thermo_rtc_command_decoder_tb_top import thermo_pkg::*;;
  typedef struct {logic [7:0] cmd; int n; logic [15:0] d;} row_s;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic conv_done = 1'b0;
  logic [15:0] temp_result = 16'h1950;
  logic [7:0] status_byte = 8'h00;
  logic [7:0] cal_rdata = 8'h5a;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic sda_o, sda_oe, conv_run, clock_alarm_clear, irq, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [7:0] config_byte;
  logic [1:0] resolution_sel, s_axi_bresp, s_axi_rresp, r;
  thresh_s thresholds;
  cal_req_s cal_req;
  wire logic scl, sda_m;
  wire logic scl_i = scl;
  wire logic sda_i = sda_m & ~sda_oe;
  logic [23:0] v;
  logic [31:0] d;
  int err_total = 0, checked = 0, cyc = 0, clr_n = 0, wr_n = 0;
  row_s rows[4] = '{'{8'hac, 1, 16'h0011}, '{8'had, 1, 16'h0001},
    '{8'ha1, 2, 16'h3200}, '{8'ha2, 2, 16'hf600}};

  link_master i_link_master (.scl, .sda_m, .sda(sda_i));
  thermo_rtc_command_decoder i_thermo_rtc_command_decoder (.*);

  always #5 mclk = ~mclk;
  // ****************************************
  // Helpers
  // ****************************************
  always @(posedge mclk) begin
    cyc++;
    clr_n += clock_alarm_clear;
    wr_n += cal_req.wr;
    if (cyc == 60000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checked %0d, err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [7:0] q[$]);
    logic a;
    i_link_master.start_c();
    i_link_master.wr_byte(8'h9e, a);
    chk(a, 1);
    foreach (q[i]) i_link_master.wr_byte(q[i], a);
  endtask : wr
  // No stop first: the command meets a repeated start
  task automatic rd(input int n);
    logic a;
    logic [7:0] b;
    v = 24'h0;
    i_link_master.start_c();
    i_link_master.wr_byte(8'h9f, a);
    for (int i = 0; i < n; i++) begin
      i_link_master.rd_byte(i == n - 1, b);
      v = {v[15:0], b};
    end
    i_link_master.stop_c();
  endtask : rd
  task automatic pulse();
    @(posedge mclk);
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : pulse
  function automatic logic [15:0] port_of(input logic [7:0] c);
    case (c)
      8'hac: return {8'h00, config_byte};
      8'had: return {14'h0, resolution_sel};
      8'ha1: return thresholds.high;
      default: return thresholds.low;
    endcase
  endfunction : port_of
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(resolution_sel, `RES_RESET);
    chk(conv_run, `CFG_RESET & 8'h01);
    i_link_master.start_c();
    i_link_master.wr_byte(8'h90, v[0]);
    i_link_master.stop_c();
    chk(v[0], 0);
    foreach (rows[i]) begin
      if (rows[i].n == 1) wr('{rows[i].cmd, rows[i].d[7:0]});
      else wr('{rows[i].cmd, rows[i].d[15:8], rows[i].d[7:0]});
      i_link_master.stop_c();
      chk(port_of(rows[i].cmd), rows[i].d);
      rd(rows[i].n);
      chk(v[15:0], rows[i].d);
      $display("end of row %0d", i);
    end
    wr('{8'haa});
    rd(2);
    chk(v[15:0], 16'h1950);
    rd(1);
    chk(v[7:0], 8'h19);
    $display("end of temperature read");
    wr('{8'hee});
    i_link_master.stop_c();
    pulse();
    chk(conv_run, 1);
    wr('{8'h22});
    i_link_master.stop_c();
    chk(conv_run, 1);
    pulse();
    chk(conv_run, 0);
    wr('{8'hac, 8'h02, 8'hff});
    wr('{8'hee});
    i_link_master.stop_c();
    chk(conv_run, 1);
    pulse();
    chk(conv_run, 0);
    $display("end of conversion control");
    wr('{8'h17, 8'h1e, 8'ha1, 8'hb2, 8'hc3});
    wr('{8'h17, 8'h1f});
    rd(2);
    chk(v[15:0], 16'hb2c3);
    wr('{8'hc0, 8'h05, 8'h30, 8'h51});
    i_link_master.stop_c();
    chk(wr_n, 2);
    wr('{8'hc7, 8'h02});
    rd(1);
    chk(v[7:0], 8'h5a);
    chk(cal_req, 18'h10251);
    chk(clr_n, 3);
    $display("end of addressed stores");
    axi_rd(`REG_EVT_STATUS);
    chk({irq, d[2:0]}, 4'h7);
    axi_wr(`REG_EVT_ENABLE, 32'h1);
    repeat (3) @(posedge mclk);
    chk(irq, 1);
    axi_wr(`REG_EVT_CLEAR, 32'h7);
    chk(r, `RESP_OKAY);
    axi_rd(`REG_EVT_STATUS);
    chk(d, 32'h0);
    chk(irq, 0);
    axi_rd(`REG_CTRL);
    chk(d, 32'h1);
    axi_rd(8'h20);
    chk(r, `RESP_SLVERR);
    $display("end of register bus");
    test_done();
  end
endmodule : thermo_rtc_command_decoder_tb_top
